// ===== sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic        clk = 1'h0;
  logic        sys_rst = 1'h1;
  logic        wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
  logic [9:0]  wb_adr_i = 10'h000;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic        wb_ack_o, readingValid, overtempTripN, resetTripReq, irq;
  logic [7:0]  tempZone0, tempZone1, tempZone2, lowLimitZone0, lowLimitZone1, lowLimitZone2;
  logic [7:0]  adj, lim, expLow;
  int          mismatches = 0, tests_run = 0;

  // 250 MHz clock
  initial forever #2 clk = ~clk;

  // Short second tick keeps the hold near 600 cycles
  temp_zone_supervisor #(.SECOND_CYCLES(10)) u_temp_zone_supervisor (.clk, .sys_rst, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .tempZone0, .tempZone1, .tempZone2,
    .readingValid, .lowLimitZone0, .lowLimitZone1, .lowLimitZone2, .overtempTripN, .resetTripReq, .irq);
  temp_zone_sequencer_model u_temp_zone_sequencer_model (.clk, .tempZone0, .tempZone1, .tempZone2, .readingValid);

  // Verdict and end of run
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report

  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  // Classic cycle; data taken while ack stands, released at the edge that sampled it
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    bit got;
    got = 1'b0;
    @(posedge clk);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, w};
    wb_adr_i <= {idx, 2'h0};
    wb_dat_i <= {24'h0, d};
    for (int i = 0; i < 20 && !got; i++)
    begin
      @(posedge clk);
      got = (wb_ack_o === 1'h1);
    end
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
    if (!got)
    begin
      mismatches++;
      final_report();
    end
  endtask : bus

  task automatic scan(input logic [7:0] t0, input logic [7:0] t1, input logic [7:0] t2);
    u_temp_zone_sequencer_model.reading(t0, t1, t2);
    @(negedge clk);
  endtask : scan

  // Shift floors at zero
  function automatic logic [7:0] shifted(input logic [7:0] low, input logic [7:0] amt);
    return (low > amt) ? low - amt : 8'h00;
  endfunction : shifted

  initial
  begin
    void'($urandom(55));
    adj = 8'h01 + 8'($urandom % 5);
    lim = 8'h30 + 8'($urandom % 16);
    repeat (3) @(posedge clk);
    sys_rst <= 1'h0;
    @(negedge clk);
    chk("low0", 8'h20, lowLimitZone0);
    chk("pin", 8'h01, {7'h0, overtempTripN});
    bus(0, 8'hB7, 8'h00);
    chk("shiftEn", 8'h00, rd[7:0]);
    bus(0, 8'h00, 8'h00);
    chk("unmapped", 8'h00, rd[7:0]);
    bus(0, 8'hC4, 8'h00);
    chk("tripR1", 8'h64, rd[7:0]);
    // Zone 0 enabled, zone 1 hot but disabled
    bus(1, 8'hB7, 8'h01);
    bus(1, 8'hE6, adj);
    bus(1, 8'hEE, 8'h01);
    scan(8'h60, 8'h60, 8'h10);
    chk("low0", 8'h20, lowLimitZone0);
    scan(8'h60, 8'h60, 8'h10);
    expLow = shifted(8'h20, adj);
    chk("low0", expLow, lowLimitZone0);
    chk("low1", 8'h20, lowLimitZone1);
    chk("low2", 8'h20, lowLimitZone2);
    chk("irq", 8'h01, {7'h0, irq});
    scan(8'h60, 8'h60, 8'h10);
    chk("low0", expLow, lowLimitZone0);
    repeat (700) @(posedge clk);
    scan(8'h60, 8'h60, 8'h10);
    expLow = shifted(expLow, adj);
    chk("low0", expLow, lowLimitZone0);
    bus(1, 8'hED, 8'h01);
    repeat (2) @(negedge clk);
    chk("irq", 8'h00, {7'h0, irq});
    // Pin from zone 0 only; zones 1 and 2 just flag status
    bus(1, 8'hCE, 8'h01);
    bus(1, 8'hC9, lim);
    scan(8'h10, 8'h70, lim + 8'h01);
    scan(8'h10, 8'h70, lim + 8'h01);
    chk("pin", 8'h01, {7'h0, overtempTripN});
    bus(0, 8'hEF, 8'h00);
    chk("tripSts", 8'h06, rd[7:0]);
    bus(0, 8'hED, 8'h00);
    chk("intSts", 8'h40, rd[7:0]);
    scan(8'h70, 8'h10, 8'h10);
    chk("pin", 8'h01, {7'h0, overtempTripN});
    scan(8'h70, 8'h10, 8'h10);
    chk("pin", 8'h00, {7'h0, overtempTripN});
    chk("rstReq", 8'h01, {7'h0, resetTripReq});
    scan(8'h10, 8'h10, 8'h10);
    chk("pin", 8'h01, {7'h0, overtempTripN});
    final_report();
  end
endmodule : tb_top

bind temp_zone_supervisor temp_zone_supervisor_assertions u_temp_zone_supervisor_assertions (.clk, .sys_rst,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .readingValid, .lowLimitZone0,
  .overtempTripN, .resetTripReq);

// ===== sim/temp_zone_sequencer_model.sv
`timescale 1ns/10ps
module temp_zone_sequencer_model (
  // Clock
  input  wire logic       clk,
  // Readings toward the supervisor
  output logic      [7:0] tempZone0,
  output logic      [7:0] tempZone1,
  output logic      [7:0] tempZone2,
  output logic            readingValid
);
  // Quiet until the first monitoring cycle
  initial
  begin
    readingValid = 1'h0;
    {tempZone0, tempZone1, tempZone2} = 24'h0;
  end

  // One reading; lines are scrambled after the pulse so stale values never look valid
  task automatic reading(input logic [7:0] t0, input logic [7:0] t1, input logic [7:0] t2);
    @(posedge clk);
    {tempZone0, tempZone1, tempZone2} <= {t0, t1, t2};
    readingValid <= 1'h1;
    @(posedge clk);
    readingValid <= 1'h0;
    {tempZone0, tempZone1, tempZone2} <= ~{t0, t1, t2};
    repeat (3) @(posedge clk);
  endtask : reading
endmodule : temp_zone_sequencer_model

// ===== sim/temp_zone_supervisor_assertions.sv
`timescale 1ns/10ps
module temp_zone_supervisor_assertions (
  // Clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // Bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [9:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Readings and outputs
  input wire logic        readingValid,
  input wire logic [7:0]  lowLimitZone0,
  input wire logic        overtempTripN,
  input wire logic        resetTripReq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Bus answers in exactly one cycle, as a single pulse
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack missing");
  upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("read upper bits set");
  unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i[9:2] == 8'h00 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  // Internal reset request mirrors the pin
  trip_copy_a: assert property (resetTripReq == !overtempTripN) else $error("trip copy differs");
  // Shifts only lower the limit, and only after a reading
  low_drop_a: assert property ($changed(lowLimitZone0) && !$past(wb_cyc_i) |-> lowLimitZone0 < $past(lowLimitZone0))
    else $error("low limit rose");
  low_cause_a: assert property ($changed(lowLimitZone0) |-> $past(readingValid) || $past(wb_cyc_i))
    else $error("low limit moved alone");
  // Pin falls only one edge after a reading, or one or two edges after a bus cycle
  trip_cause_a: assert property ($fell(overtempTripN) |-> $past(readingValid) || $past(wb_cyc_i)
    || $past(wb_cyc_i, 2)) else $error("trip pin fell alone");
endmodule : temp_zone_supervisor_assertions

// ===== verilog/temp_zone_cfg.svh
`ifndef TEMP_ZONE_CFG_SVH
`define TEMP_ZONE_CFG_SVH

// Register indices; the byte address is four times the index
`define TZS_IDX_SHIFT_EN   8'hB7
`define TZS_IDX_TRIP_R1    8'hC4
`define TZS_IDX_TRIP_R2    8'hC5
`define TZS_IDX_TRIP_AMB   8'hC9
`define TZS_IDX_TRIP_SRC   8'hCE
`define TZS_IDX_LOW0       8'hE0
`define TZS_IDX_TOP0       8'hE3
`define TZS_IDX_ADJ0       8'hE6
`define TZS_IDX_DELAY      8'hE9
`define TZS_IDX_HIGH0      8'hEA
`define TZS_IDX_INT_STS    8'hED
`define TZS_IDX_INT_MASK   8'hEE
`define TZS_IDX_TRIP_STS   8'hEF

// Interrupt status field positions
`define TZS_STS_SHIFT_LSB  0
`define TZS_STS_HIGH_LSB   3
`define TZS_STS_TRIP_BIT   6

// Reset values
`define TZS_RST_LOW        8'h20
`define TZS_RST_TOP        8'h50
`define TZS_RST_ADJ        8'h02
`define TZS_RST_HIGH       8'h7F
`define TZS_RST_TRIP       8'h64

// Timing: delay unit and the one-second tick
`define TZS_CLK_PERIOD_NS  4
`define TZS_SECOND_NS      1000000000
`define TZS_MINUTE_S       60

`endif

// ===== verilog/temp_zone_pkg.sv
package temp_zone_pkg;

  typedef logic [7:0] byte_t;

  // Per-zone shift phase
  typedef enum logic {
    ZONE_ARMED,
    ZONE_HOLD
  } zone_phase_e;

  // Whole state of the supervisor
  typedef struct packed {
    byte_t [2:0]       lowLimit;
    byte_t [2:0]       topTemp;
    byte_t [2:0]       adjust;
    byte_t [2:0]       highLimit;
    byte_t [2:0]       tripLimit;
    logic  [5:0]       delaySel;
    logic  [2:0]       shiftEn;
    logic  [2:0]       tripSrc;
    logic  [7:0]       intStatus;
    logic  [7:0]       intMask;
    logic  [2:0]       tripStatus;
    logic  [2:0]       topPrev;
    logic  [2:0]       tripPrev;
    logic  [2:0]       tripQual;
    zone_phase_e [2:0] phase;
    byte_t [2:0]       holdSec;
    logic  [27:0]      tickCnt;
    logic              ack;
    logic  [31:0]      rdat;
    logic              tripN;
    logic              tripInt;
    logic              irq;
  } tzs_state_s;

endpackage : temp_zone_pkg

// ===== verilog/temp_zone_supervisor.sv
// Contract
// R01 - Over top: low limit minus adjustment
// R02 - Per-zone shift enable at B7
// R03 - Shift only after two consecutive exceeds
// R04 - Repeat shifts while still over top
// R05 - Hold one to four minutes after shift
// R06 - Shift amount from per-zone adjust register
// R07 - Top ignored when shift disabled
// R08 - Trip source select at CE gates pin
// R09 - Trip limits at C4, C5, C9
// R10 - Trip and high limits compared independently
// R11 - Trip status set regardless of enable
// R12 - Pin asserted only for enabled zones
// R13 - Trip needs two consecutive exceeds
// R14 - Internal trip copy to reset generator
// R15 - Trip pin active low while qualified
// R16 - Shift status raises interrupt when unmasked
//
// The Wishbone register port was decided locally.
`timescale 1ns/10ps
`include "temp_zone_cfg.svh"

module temp_zone_supervisor #(
  parameter int SECOND_CYCLES = `TZS_SECOND_NS / `TZS_CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Classic Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Readings from the monitoring sequencer
  input  wire logic [7:0]  tempZone0,
  input  wire logic [7:0]  tempZone1,
  input  wire logic [7:0]  tempZone2,
  input  wire logic        readingValid,
  // Adjusted low limits to the autofan logic
  output logic      [7:0]  lowLimitZone0,
  output logic      [7:0]  lowLimitZone1,
  output logic      [7:0]  lowLimitZone2,
  // Trip and interrupt outputs
  output logic             overtempTripN,
  output logic             resetTripReq,
  output logic             irq
);

  temp_zone_pkg::tzs_state_s st;
  temp_zone_pkg::tzs_state_s next_st;

  logic [2:0][7:0] temp;
  logic [7:0]      idx;
  logic            req;
  logic            wrNow;
  logic            secTick;
  logic            topOver;
  logic            tripOver;
  logic [2:0]      setShift;
  logic [2:0]      setHigh;
  logic [2:0]      setTrip;
  logic [7:0]      stsClr;
  logic [2:0]      tripClr;
  logic [31:0]     rd;

  // Register map, by word index on the bus
  // Shift enable: one bit per zone in the low three bits
  // Trip limits: remote one, remote two and ambient
  // Trip source select: one pin enable bit per zone
  // Low limits: three words from the low base upward
  // Top temperatures: three words from the top base upward
  // Adjust amounts: three words from the adjust base upward
  // Delay select: two bits per zone, zone z at bit 2z
  // High limits: three words from the high base upward
  // Interrupt status: shift, high and trip fields
  // Interrupt mask: same layout as the status word
  // Trip status: one sticky bit per zone
  // Unmapped words read as zero and ignore writes
  // Only byte lane zero carries register data

  // Bus timing seen by a master
  // A request is taken while no ack is pending
  // Ack follows one cycle later, always a single pulse
  // Read data is captured when the request is taken
  // A write lands on the edge that sees ack high
  // The master must drop the request for one cycle
  // A held request is therefore acked again every second cycle

  // Reading pipeline
  // Each reading pulse updates the previous-exceed flags
  // Two exceeds in a row are needed before a shift or a trip
  // A single noisy reading never moves a limit
  // A single noisy reading never asserts the trip pin
  // The pin releases on the first reading not over
  // Status bits stay set until software clears them

  // Hold timer
  // A free-running tick divides the clock to seconds
  // Sharing one tick keeps each zone counter eight bits
  // The cost is a hold up to one tick short
  // A zone in hold ignores further shift requests
  // The exceed flag keeps tracking during the hold
  // So a still-hot zone shifts right after the hold

  // Limit arithmetic
  // The low limit saturates at zero instead of wrapping
  // A wrapped limit would push the fan to full speed
  // A software write wins over a same-cycle shift

  // Saturating subtract keeps the low limit from wrapping to a hot value
  function automatic logic [7:0] satSub(input logic [7:0] a, input logic [7:0] b);
    satSub = (a > b) ? (a - b) : 8'h00;
  endfunction : satSub

  // Hold time in seconds for a two-bit delay selection
  function automatic logic [7:0] holdSeconds(input logic [1:0] sel);
    logic [7:0] mins;
    mins = {6'h00, sel} + 8'h01;
    holdSeconds = 8'(mins * 8'(`TZS_MINUTE_S));
  endfunction : holdSeconds

  // Decode of a per-zone register from its base index
  function automatic logic isZoneReg(input logic [7:0] a, input logic [7:0] base, input int z);
    isZoneReg = (a == 8'(base + 8'(z)));
  endfunction : isZoneReg

  // Pack readings and decode the bus request
  assign temp  = {tempZone2, tempZone1, tempZone0};
  assign idx   = wb_adr_i[9:2];
  assign req   = wb_cyc_i & wb_stb_i;
  assign wrNow = req & st.ack & wb_we_i & wb_sel_i[0];

  // Next-state logic for the whole block
  always_comb
  begin
    next_st  = st;
    setShift = 3'h0;
    setHigh  = 3'h0;
    setTrip  = 3'h0;
    stsClr   = 8'h00;
    tripClr  = 3'h0;
    rd       = 32'h0000_0000;
    topOver  = 1'b0;
    tripOver = 1'b0;

    // One-second tick keeps the minute counters narrow
    secTick = (st.tickCnt == 28'(SECOND_CYCLES - 1));
    next_st.tickCnt = secTick ? 28'h000_0000 : st.tickCnt + 28'h000_0001;

    // Hold countdown after each shift
    for (int z = 0; z < 3; z++)
    begin
      if (st.phase[z] == temp_zone_pkg::ZONE_HOLD && secTick)
      begin
        // R05 re-arm after delay
        if (st.holdSec[z] <= 8'h01)
        begin
          next_st.phase[z]   = temp_zone_pkg::ZONE_ARMED;
          next_st.holdSec[z] = 8'h00;
        end
        else
        begin
          next_st.holdSec[z] = st.holdSec[z] - 8'h01;
        end
      end
    end

    // Per-reading comparisons, once per monitoring cycle
    if (readingValid)
    begin
      for (int z = 0; z < 3; z++)
      begin
        // R07 top ignored when disabled
        // R02 per-zone shift enable
        topOver = st.shiftEn[z] && (temp[z] > st.topTemp[z]);
        next_st.topPrev[z] = topOver;

        // R03 two successive exceeds
        // R04 repeat while still hot
        if (topOver && st.topPrev[z] && st.phase[z] == temp_zone_pkg::ZONE_ARMED)
        begin
          // R01 reload reduced low limit
          // R06 amount from adjust register
          next_st.lowLimit[z] = satSub(st.lowLimit[z], st.adjust[z]);
          setShift[z]         = 1'b1;
          // R05 start hold delay
          next_st.phase[z]    = temp_zone_pkg::ZONE_HOLD;
          next_st.holdSec[z]  = holdSeconds(st.delaySel[2*z +: 2]);
        end

        // R09 compare against trip limit
        tripOver = temp[z] > st.tripLimit[z];
        next_st.tripPrev[z] = tripOver;
        // R13 qualify on two readings
        next_st.tripQual[z] = tripOver && st.tripPrev[z];
        // R11 status independent of enable
        setTrip[z] = tripOver && st.tripPrev[z];

        // R10 high limit checked separately
        setHigh[z] = temp[z] > st.highLimit[z];
      end
    end

    // Read mux; unmapped indices read as zero
    case (idx)
      `TZS_IDX_SHIFT_EN: rd[2:0] = st.shiftEn;
      `TZS_IDX_TRIP_R1:  rd[7:0] = st.tripLimit[0];
      `TZS_IDX_TRIP_R2:  rd[7:0] = st.tripLimit[1];
      `TZS_IDX_TRIP_AMB: rd[7:0] = st.tripLimit[2];
      `TZS_IDX_TRIP_SRC: rd[2:0] = st.tripSrc;
      `TZS_IDX_DELAY:    rd[5:0] = st.delaySel;
      `TZS_IDX_INT_STS:  rd[7:0] = st.intStatus;
      `TZS_IDX_INT_MASK: rd[7:0] = st.intMask;
      `TZS_IDX_TRIP_STS: rd[2:0] = st.tripStatus;
      default:           rd      = 32'h0000_0000;
    endcase
    for (int z = 0; z < 3; z++)
    begin
      if (isZoneReg(idx, `TZS_IDX_LOW0, z))
      begin
        rd[7:0] = st.lowLimit[z];
      end
      if (isZoneReg(idx, `TZS_IDX_TOP0, z))
      begin
        rd[7:0] = st.topTemp[z];
      end
      if (isZoneReg(idx, `TZS_IDX_ADJ0, z))
      begin
        rd[7:0] = st.adjust[z];
      end
      if (isZoneReg(idx, `TZS_IDX_HIGH0, z))
      begin
        rd[7:0] = st.highLimit[z];
      end
    end

    // Bus handshake: ack one cycle after the request, data captured with it
    next_st.ack = req & ~st.ack;
    if (req & ~st.ack)
    begin
      next_st.rdat = rd;
    end

    // Writes land on the edge where the master sees ack
    if (wrNow)
    begin
      case (idx)
        // R02 enable bits
        `TZS_IDX_SHIFT_EN: next_st.shiftEn = wb_dat_i[2:0];
        // R09 trip limit registers
        `TZS_IDX_TRIP_R1:  next_st.tripLimit[0] = wb_dat_i[7:0];
        `TZS_IDX_TRIP_R2:  next_st.tripLimit[1] = wb_dat_i[7:0];
        `TZS_IDX_TRIP_AMB: next_st.tripLimit[2] = wb_dat_i[7:0];
        // R08 trip source select
        `TZS_IDX_TRIP_SRC: next_st.tripSrc = wb_dat_i[2:0];
        `TZS_IDX_DELAY:    next_st.delaySel = wb_dat_i[5:0];
        `TZS_IDX_INT_STS:  stsClr = wb_dat_i[7:0];
        `TZS_IDX_INT_MASK: next_st.intMask = wb_dat_i[7:0];
        `TZS_IDX_TRIP_STS: tripClr = wb_dat_i[2:0];
        default:           next_st.intMask = next_st.intMask;
      endcase
      for (int z = 0; z < 3; z++)
      begin
        // Software write of a low limit overrides a same-cycle shift
        if (isZoneReg(idx, `TZS_IDX_LOW0, z))
        begin
          next_st.lowLimit[z] = wb_dat_i[7:0];
        end
        if (isZoneReg(idx, `TZS_IDX_TOP0, z))
        begin
          next_st.topTemp[z] = wb_dat_i[7:0];
        end
        // R06 adjust register
        if (isZoneReg(idx, `TZS_IDX_ADJ0, z))
        begin
          next_st.adjust[z] = wb_dat_i[7:0];
        end
        if (isZoneReg(idx, `TZS_IDX_HIGH0, z))
        begin
          next_st.highLimit[z] = wb_dat_i[7:0];
        end
      end
    end

    // Sticky status: a set in the clear cycle survives
    next_st.intStatus = st.intStatus & ~stsClr;
    next_st.intStatus[`TZS_STS_SHIFT_LSB +: 3] = next_st.intStatus[`TZS_STS_SHIFT_LSB +: 3] | setShift;
    next_st.intStatus[`TZS_STS_HIGH_LSB +: 3]  = next_st.intStatus[`TZS_STS_HIGH_LSB +: 3] | setHigh;
    next_st.intStatus[`TZS_STS_TRIP_BIT]       = next_st.intStatus[`TZS_STS_TRIP_BIT] | (|setTrip);
    next_st.intStatus[7] = 1'b0;
    // R11 trip status sticky
    next_st.tripStatus = (st.tripStatus & ~tripClr) | setTrip;

    // R12 only enabled zones drive the pin
    // R15 low while qualified
    next_st.tripN   = ~|(next_st.tripQual & next_st.tripSrc);
    // R14 copy to reset generator
    next_st.tripInt = |(next_st.tripQual & next_st.tripSrc);
    // R16 unmasked status raises interrupt
    next_st.irq     = |(next_st.intStatus & next_st.intMask);
  end

  // Status policy
  // A hardware set in the clear cycle wins
  // Software never loses an event it has not seen
  // The top status bit is reserved and reads zero
  // Shift bits follow each completed adjustment
  // High bits follow each reading over its high limit
  // The trip bit follows any qualified trip

  // Trip path
  // The pin and the reset request share one term
  // Both come from flops, so they change together
  // A disabled zone still records its trip status
  // Only enabled zones may pull the pin low
  // The reset generator sees the active-high copy

  // Interrupt path
  // The interrupt is a level, not a pulse
  // It stays high while any unmasked bit is set
  // Clearing the status or the mask drops it
  // It changes on the same edge as the status

  // Reset behaviour
  // All limits return to their reset values
  // All zones return to the armed phase
  // The pin comes out of reset released
  // No ack is pending after reset
  // The tick counter restarts from zero

  // Limitations
  // Readings are taken as synchronous to the clock
  // The delay is measured in whole ticks only
  // Only three zones are supported
  // Writes with lane zero disabled are dropped
  // Reads of reserved fields return zero
  // The shift amount is not checked against the range
  // A zero adjust value leaves the limit unchanged
  // Software may rewrite a shifted limit at any time
  // The new value then becomes the base for shifts
  // Top temperatures are ignored while shifts are off
  // The exceed flag is cleared while shifts are off
  // Enabling shifts again needs two fresh exceeds

  // State register with constant reset values
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st              <= '0;
      st.lowLimit     <= {3{`TZS_RST_LOW}};
      st.topTemp      <= {3{`TZS_RST_TOP}};
      st.adjust       <= {3{`TZS_RST_ADJ}};
      st.highLimit    <= {3{`TZS_RST_HIGH}};
      st.tripLimit    <= {3{`TZS_RST_TRIP}};
      st.phase        <= {3{temp_zone_pkg::ZONE_ARMED}};
      st.tripN        <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Outputs straight from state flops
  assign wb_dat_o      = st.rdat;
  assign wb_ack_o      = st.ack;
  assign lowLimitZone0 = st.lowLimit[0];
  assign lowLimitZone1 = st.lowLimit[1];
  assign lowLimitZone2 = st.lowLimit[2];
  assign overtempTripN = st.tripN;
  assign resetTripReq  = st.tripInt;
  assign irq           = st.irq;

endmodule : temp_zone_supervisor
